// *** src/can_ctrl_pkg.sv ***
/*
 * Shared constants and carrier types for the CAN buffer control block.
 * Assumes a 16-bit register port and a protocol engine outside the block.
 */
package can_ctrl_pkg;
    // ------------------------------------------------------------------
    // register map (word offsets on the register port)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_TIMING = 8'h00;
    localparam logic [7:0] OFF_INT_STATUS = 8'h01;
    localparam logic [7:0] OFF_INT_MASK = 8'h02;
    localparam logic [7:0] OFF_ENGINE_STATUS = 8'h03;
    localparam logic [7:0] OFF_PAIR_BASE = 8'h08;   // four pair words
    localparam logic [7:0] OFF_SID_BASE = 8'h10;    // sixteen filters
    localparam logic [7:0] OFF_EID_BASE = 8'h20;    // sixteen filters

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int SJW_LSB = 6;
    localparam int PRESC_LSB = 0;
    localparam logic [15:0] TIMING_MASK = 16'h00FF;
    localparam logic [15:0] SID_MASK = 16'hFFEB;    // bits 4 and 2 unused
    localparam int SID_LSB = 5;
    localparam int FRAME_TYPE_SELECT_BIT = 3;
    localparam int BUF_DIR = 7;
    localparam int BUF_ABT = 6;
    localparam int BUF_LARB = 5;
    localparam int BUF_ERR = 4;
    localparam int BUF_REQ = 3;
    localparam int BUF_RTR = 2;
    localparam int BUF_PRI_LSB = 0;
    localparam logic [7:0] BUF_SW_MASK = 8'h8F;     // writable bits
    localparam logic [7:0] BUF_RESET = 8'h00;

    // interrupt status bits
    localparam int IRQ_SENT = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_LARB = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_MATCH = 4;
    localparam int IRQ_W = 5;

    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // identifier received by the protocol engine
    typedef struct packed {
        logic valid;
        logic extended;
        logic remote;
        logic [10:0] standard_ident_bits;
        logic [17:0] extended_ident_bits;
    } rx_ident_t;

    // outcome reported by the protocol engine for the buffer it sends
    typedef struct packed {
        logic done;
        logic aborted;
        logic lost_arb;
        logic bus_err;
    } tx_result_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_BUSY = 3'b010,
        TX_ABORT = 3'b100
    } tx_state_t;
endpackage

// *** src/can_buffer_ctrl.sv ***
/*
 * Bit-timing setup, acceptance filters and paired buffer control of a CAN
 * controller. Assumes an external protocol engine that takes the chosen
 * buffer, reports each send outcome and presents received identifiers.
 */
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps

// What this block does
// R1: jump width is field plus one quanta
// R2: quantum is two times prescaler plus one
// R3: eleven stored standard bits must all match
// R4: type enforce makes frame select pick kind
// R5: extended top bits live in standard word
// R6: sixteen low extended bits must match
// R7: pair word: low even buffer, high odd
// R8: direction bit set means transmit, resets receive
// R9: aborted flag set on abort, zero success
// R10: lost arbitration flag set on loss
// R11: transmit error flag set on bus error
// R12: setting send request clears three flags
// R13: send request queues, cleared on success
// R14: clearing pending request aborts, sets aborted
// R15: auto remote reply sets send request
// R16: two-bit priority, eleven highest
// R17: highest priority first, ties to higher number
module can_buffer_ctrl
    import can_ctrl_pkg::*;
#(
    parameter int NBUF = 8,
    parameter int NFILT = 16
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire rx_ident_t RX_IDENT,
    input wire logic [NFILT-1:0] FILTER_TYPE_ENFORCE,
    input wire tx_result_t TX_RESULT,
    output logic TX_START,
    output logic [2:0] TX_BUFFER,
    output logic TX_ABORT_REQ,
    output logic QUANTUM_TICK,
    output logic [2:0] RESYNC_JUMP_WIDTH,
    output logic [NFILT-1:0] FILTER_HIT,
    output logic IRQ
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] timing_reg;
    logic [15:0] sid_reg [NFILT];
    logic [15:0] eid_reg [NFILT];
    logic [7:0] buf_reg [NBUF];
    logic [IRQ_W-1:0] istat_reg;
    logic [IRQ_W-1:0] imask_reg;
    tx_state_t state_reg;
    logic [2:0] cur_reg;
    logic [6:0] qcnt_reg;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire hit_timing = (ADDR == OFF_TIMING);
    wire hit_istat = (ADDR == OFF_INT_STATUS);
    wire hit_imask = (ADDR == OFF_INT_MASK);
    wire hit_eng = (ADDR == OFF_ENGINE_STATUS);
    wire hit_pair = (ADDR[7:2] == OFF_PAIR_BASE[7:2]);
    wire hit_sid = (ADDR[7:4] == OFF_SID_BASE[7:4]);
    wire hit_eid = (ADDR[7:4] == OFF_EID_BASE[7:4]);
    wire [1:0] pair_idx = ADDR[1:0];
    wire [3:0] filt_idx = ADDR[3:0];

    // ------------------------------------------------------------------
    // time quantum divider
    // ------------------------------------------------------------------
    // quantum length in module clocks, 2 to 128
    function automatic logic [7:0] quantum_len(input logic [5:0] presc);
        quantum_len = {1'b0, presc, 1'b0} + 8'h02; // R2
    endfunction

    wire [7:0] q_len = quantum_len(timing_reg[PRESC_LSB +: 6]);
    wire q_wrap = ({1'b0, qcnt_reg} == q_len - 8'h01);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            qcnt_reg <= 7'h00;
            QUANTUM_TICK <= 1'b0;
            RESYNC_JUMP_WIDTH <= 3'h1;
        end else begin
            qcnt_reg <= q_wrap ? 7'h00 : qcnt_reg + 7'h01;
            QUANTUM_TICK <= q_wrap; // R2
            RESYNC_JUMP_WIDTH <= {1'b0, timing_reg[SJW_LSB +: 2]} + 3'h1; // R1
        end
    end

    // ------------------------------------------------------------------
    // acceptance filters
    // ------------------------------------------------------------------
    // one filter compares the eleven standard bits, and the eighteen extended bits only for extended frames
    function automatic logic filter_match(input logic [15:0] sw,
                                          input logic [15:0] ew,
                                          input logic enforce,
                                          input rx_ident_t id);
        logic sid_ok;
        logic eid_ok;
        logic type_ok;
        sid_ok = (sw[SID_LSB +: 11] == id.standard_ident_bits); // R3
        eid_ok = !id.extended
            || ({sw[1:0], ew} == id.extended_ident_bits); // R5 R6
        type_ok = !enforce || (sw[FRAME_TYPE_SELECT_BIT] == id.extended); // R4
        filter_match = sid_ok && eid_ok && type_ok;
    endfunction

    logic [NFILT-1:0] hit_vec;
    always_comb begin
        for (int f = 0; f < NFILT; f++) begin
            hit_vec[f] = RX_IDENT.valid
                && filter_match(sid_reg[f], eid_reg[f],
                                FILTER_TYPE_ENFORCE[f], RX_IDENT);
        end
    end
    wire any_hit = |hit_vec;
    // remote request matching any filter triggers buffers with auto reply
    wire rtr_hit = any_hit && RX_IDENT.remote;

    // ------------------------------------------------------------------
    // transmit arbitration
    // ------------------------------------------------------------------
    logic pick_valid;
    logic [2:0] pick_idx;
    logic [1:0] pick_pri;
    always_comb begin
        pick_valid = 1'b0;
        pick_idx = 3'h0;
        pick_pri = 2'h0;
        // ascending scan with >= lets higher numbers win ties
        for (int b = 0; b < NBUF; b++) begin
            if (buf_reg[b][BUF_DIR] && buf_reg[b][BUF_REQ]
                && (!pick_valid || buf_reg[b][BUF_PRI_LSB +: 2] >= pick_pri)
                ) begin
                pick_valid = 1'b1; // R17 R16
                pick_idx = 3'(b);
                pick_pri = buf_reg[b][BUF_PRI_LSB +: 2];
            end
        end
    end

    wire cur_req = buf_reg[cur_reg][BUF_REQ];

    // ------------------------------------------------------------------
    // engine sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= TX_IDLE;
            cur_reg <= 3'h0;
            TX_START <= 1'b0;
            TX_BUFFER <= 3'h0;
            TX_ABORT_REQ <= 1'b0;
        end else begin
            TX_START <= 1'b0;
            TX_ABORT_REQ <= 1'b0;
            case (state_reg)
                TX_IDLE: begin
                    if (pick_valid) begin
                        state_reg <= TX_BUSY; // R13
                        cur_reg <= pick_idx;
                        TX_BUFFER <= pick_idx;
                        TX_START <= 1'b1;
                    end
                end
                TX_BUSY: begin
                    if (TX_RESULT.done) begin
                        state_reg <= TX_IDLE;
                    end else if (!cur_req) begin
                        state_reg <= TX_ABORT; // R14
                        TX_ABORT_REQ <= 1'b1;
                    end
                end
                TX_ABORT: begin
                    if (TX_RESULT.done) begin
                        state_reg <= TX_IDLE;
                    end
                end
                default: state_reg <= TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // buffer control words
    // ------------------------------------------------------------------
    wire busy = (state_reg != TX_IDLE);
    wire res_done = busy && TX_RESULT.done;
    wire res_ok = res_done && !TX_RESULT.aborted
        && !TX_RESULT.lost_arb && !TX_RESULT.bus_err;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int b = 0; b < NBUF; b++) begin
                buf_reg[b] <= BUF_RESET; // R8
            end
        end else begin
            for (int b = 0; b < NBUF; b++) begin
                logic [7:0] v;
                logic wsel;
                v = buf_reg[b];
                wsel = WR && hit_pair && (pair_idx == 2'(b / 2));
                if (wsel) begin
                    // even buffer low byte, odd buffer high byte
                    v = (v & ~BUF_SW_MASK)
                        | (WDATA[(b % 2) * 8 +: 8] & BUF_SW_MASK); // R7
                end
                if (res_done && cur_reg == 3'(b)) begin
                    if (res_ok) begin
                        v[BUF_REQ] = 1'b0; // R13
                    end
                    if (TX_RESULT.aborted) begin
                        v[BUF_ABT] = 1'b1; // R9 R14
                    end
                    if (TX_RESULT.lost_arb) begin
                        v[BUF_LARB] = 1'b1; // R10
                    end
                    if (TX_RESULT.bus_err) begin
                        v[BUF_ERR] = 1'b1; // R11
                    end
                end
                if (rtr_hit && v[BUF_RTR]) begin
                    v[BUF_REQ] = 1'b1; // R15
                end
                if (v[BUF_REQ] && !buf_reg[b][BUF_REQ]) begin
                    v[BUF_ABT] = 1'b0; // R12
                    v[BUF_LARB] = 1'b0;
                    v[BUF_ERR] = 1'b0;
                end
                buf_reg[b] <= v;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration and filter words
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            timing_reg <= 8'h00;
            imask_reg <= '0;
        end else begin
            if (WR && hit_timing) begin
                timing_reg <= WDATA[7:0];
            end
            if (WR && hit_imask) begin
                imask_reg <= WDATA[IRQ_W-1:0];
            end
        end
    end

    // filter words hold no reset value
    always_ff @(posedge CLK) begin
        if (WR && hit_sid) begin
            sid_reg[filt_idx] <= WDATA & SID_MASK; // R5
        end
        if (WR && hit_eid) begin
            eid_reg[filt_idx] <= WDATA; // R6
        end
    end

    // ------------------------------------------------------------------
    // interrupts: sticky, write one to clear, set beats clear
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] ev;
    always_comb begin
        ev = '0;
        ev[IRQ_SENT] = res_ok;
        ev[IRQ_ABORT] = res_done && TX_RESULT.aborted;
        ev[IRQ_LARB] = res_done && TX_RESULT.lost_arb;
        ev[IRQ_ERR] = res_done && TX_RESULT.bus_err;
        ev[IRQ_MATCH] = any_hit;
    end
    wire [IRQ_W-1:0] clr = (WR && hit_istat) ? WDATA[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] istat_next = (istat_reg & ~clr) | ev;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            istat_reg <= '0;
            IRQ <= 1'b0;
            FILTER_HIT <= '0;
        end else begin
            istat_reg <= istat_next;
            IRQ <= |(istat_next & imask_reg);
            FILTER_HIT <= hit_vec;
        end
    end

    // ------------------------------------------------------------------
    // read port: data one cycle after the strobe
    // ------------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = UNMAPPED_READ;
        if (hit_timing) begin
            rd_mux = {8'h00, timing_reg} & TIMING_MASK;
        end else if (hit_istat) begin
            rd_mux = 16'(istat_reg);
        end else if (hit_imask) begin
            rd_mux = 16'(imask_reg);
        end else if (hit_eng) begin
            rd_mux = {10'h000, busy, cur_reg, pick_valid, pick_idx[0]};
        end else if (hit_pair) begin
            rd_mux = {buf_reg[{pair_idx, 1'b1}], buf_reg[{pair_idx, 1'b0}]};
        end else if (hit_sid) begin
            rd_mux = sid_reg[filt_idx];
        end else if (hit_eid) begin
            rd_mux = eid_reg[filt_idx];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            RDATA <= rd_mux;
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule // can_buffer_ctrl

// *** sim/can_engine_model.sv ***
/* Send engine model facing the buffer control block.
   Assumes start and abort requests are one-clock pulses. */
`timescale 1ns/100ps
module can_engine_model
    import can_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic abort_req,
    input wire logic [1:0] outcome,
    input wire logic slow,
    output tx_result_t result
);
    logic busy_reg;
    logic [1:0] kind_reg;
    logic [3:0] cnt_reg;
    logic [2:0] pat_reg;
    // one send at a time; qualifiers toggle while done is low
    always_ff @(posedge clk) begin
        pat_reg <= pat_reg + 3'h1;
        result <= {1'b0, pat_reg};
        if (!rst_n) begin
            busy_reg <= 1'b0;
            pat_reg <= 3'h0;
            cnt_reg <= 4'h0;
        end else if (start) begin
            busy_reg <= 1'b1;
            kind_reg <= outcome;
            cnt_reg <= slow ? 4'h6 : 4'h1;
        end else if (busy_reg && abort_req) begin
            busy_reg <= 1'b0;
            result <= 4'hC;
        end else if (busy_reg && cnt_reg == 4'h0) begin
            busy_reg <= 1'b0;
            result <= {2'b10, kind_reg == 2'h1, kind_reg == 2'h2};
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule // can_engine_model

// *** sim/can_buffer_ctrl_chk.sv ***
/* Port checker for the buffer control block.
   Assumes one clock domain and the package register map. */
`timescale 1ns/100ps
module can_buffer_ctrl_chk
    import can_ctrl_pkg::*;
#(
    parameter int NFILT = 16
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire rx_ident_t RX_IDENT,
    input wire tx_result_t TX_RESULT,
    input wire logic TX_START,
    input wire logic [2:0] TX_BUFFER,
    input wire logic TX_ABORT_REQ,
    input wire logic QUANTUM_TICK,
    input wire logic [2:0] RESYNC_JUMP_WIDTH,
    input wire logic [NFILT-1:0] FILTER_HIT,
    input wire logic IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic [5:0] presc_reg;
    logic [7:0] gap_reg;
    logic ok_reg, busy_reg;
    logic [15:0] mask_reg;
    wire tm_wr = WR && ADDR == OFF_TIMING;
    // shadow prescaler, tick spacing, mask and engine activity
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ok_reg <= 1'b0;
            busy_reg <= 1'b0;
            presc_reg <= 6'h00;
            mask_reg <= 16'h0000;
        end else begin
            ok_reg <= !tm_wr && (ok_reg || QUANTUM_TICK);
            busy_reg <= TX_START || busy_reg && !TX_RESULT.done;
            if (tm_wr) presc_reg <= WDATA[5:0];
            if (WR && ADDR == OFF_INT_MASK) mask_reg <= WDATA;
        end
        gap_reg <= QUANTUM_TICK ? 8'h00 : gap_reg + 8'h01;
    end
    property p_irq(logic f, logic m);
        TX_RESULT.done && busy_reg && f && m |-> ##[1:2] IRQ;
    endproperty
    chk_jump_width: assert property (tm_wr |-> ##2
        RESYNC_JUMP_WIDTH == {1'b0, $past(WDATA[7:6], 2)} + 3'h1)
        else $error("jump width wrong");
    chk_tick_period: assert property (QUANTUM_TICK && ok_reg |->
        gap_reg == {1'b0, presc_reg, 1'b1}) else $error("quantum wrong");
    chk_hit_cause: assert property (FILTER_HIT != '0 |->
        $past(RX_IDENT.valid)) else $error("hit without ident");
    chk_abort_cause: assert property (TX_ABORT_REQ |->
        $past(WR, 2) && $past(ADDR[7:2], 2) == 6'h02)
        else $error("stray abort");
    chk_start_pulse: assert property (TX_START |=> !TX_START)
        else $error("start too long");
    chk_buffer_holds: assert property (!TX_START |->
        $stable(TX_BUFFER)) else $error("buffer index moved");
    chk_irq_lost: assert property (
        p_irq(TX_RESULT.lost_arb, mask_reg[IRQ_LARB]))
        else $error("lost arbitration irq missing");
    chk_irq_err: assert property (
        p_irq(TX_RESULT.bus_err, mask_reg[IRQ_ERR]))
        else $error("bus error irq missing");
    cov_start: cover property (TX_START);
    cov_abort: cover property (TX_ABORT_REQ);
    cov_hit: cover property (FILTER_HIT[0]);
endmodule // can_buffer_ctrl_chk

bind can_buffer_ctrl can_buffer_ctrl_chk #(.NFILT(NFILT)) i_chk (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RX_IDENT(RX_IDENT), .TX_RESULT(TX_RESULT), .TX_START(TX_START),
    .TX_BUFFER(TX_BUFFER), .TX_ABORT_REQ(TX_ABORT_REQ),
    .QUANTUM_TICK(QUANTUM_TICK), .RESYNC_JUMP_WIDTH(RESYNC_JUMP_WIDTH),
    .FILTER_HIT(FILTER_HIT), .IRQ(IRQ));

// *** sim/can_buffer_ctrl_tb.sv ***
/* Bench for the buffer control block with the engine model behind it.
   Assumes package, model and checker are compiled first. */
`timescale 1ns/100ps
module can_buffer_ctrl_tb
    import can_ctrl_pkg::*;
;
    logic clk, rst_n, wr_s, rd_s, slow, tx_start, tx_abort, qtick, irq;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, enf, fhit;
    rx_ident_t rx_id;
    tx_result_t tx_res;
    logic [2:0] tx_buf, rjw;
    logic [1:0] outcome;
    logic [2:0] started[$];
    int errors, cmp_count, n;
    can_buffer_ctrl i_can_buffer_ctrl (.CLK(clk), .RST_N(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
        .RX_IDENT(rx_id), .FILTER_TYPE_ENFORCE(enf), .TX_RESULT(tx_res),
        .TX_START(tx_start), .TX_BUFFER(tx_buf), .TX_ABORT_REQ(tx_abort),
        .QUANTUM_TICK(qtick), .RESYNC_JUMP_WIDTH(rjw), .FILTER_HIT(fhit),
        .IRQ(irq));
    can_engine_model i_can_engine_model (.clk(clk), .rst_n(rst_n),
        .start(tx_start), .abort_req(tx_abort), .outcome(outcome),
        .slow(slow), .result(tx_res));
    // clock and log of started buffers
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (tx_start) started.push_back(tx_buf);
    // ------------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rc(logic [7:0] a, logic [15:0] m, logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk("read", rdata & m, e);
    endtask
    task automatic rx(logic e, logic r, logic [10:0] s, logic [17:0] x,
                      logic h);
        @(posedge clk);
        rx_id <= {1'b1, e, r, s, x};
        @(posedge clk);
        rx_id <= {1'b0, ~e, ~r, ~s, ~x};
        #1 chk("hit", {15'h0, fhit[0]}, {15'h0, h});
    endtask
    task automatic ws(logic [2:0] b);
        for (n = 0; started.size() == 0 && n < 100; n++) @(posedge clk);
        // an empty log means no start came, which must not pass as buffer 0
        chk("start", (started.size() > 0) ? {13'h0, started.pop_front()}
            : 16'hFFFF, {13'h0, b});
    endtask
    task automatic wd();
        for (n = 0; tx_res.done !== 1'b1 && n < 100; n++) @(posedge clk);
        chk("done wait", 16'(n < 100), 16'h0001);
        repeat (3) @(posedge clk);
    endtask
    task automatic tk();
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (!qtick && n < 300);
    endtask
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        errors++;
        complete_run();
    end
    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n, wr_s, rd_s, addr, wdata, rx_id} <= '0;
        {enf, outcome, slow} <= '0;
        errors = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rc(OFF_TIMING, 16'hFFFF, 16'h0000);
        rc(OFF_PAIR_BASE, 16'hFFFF, 16'h0000);
        wr(8'h05, 16'hFFFF);
        rc(8'h05, 16'hFFFF, 16'h0000);
        wr(8'h0A, 16'h7070);
        rc(8'h0A, 16'hFFFF, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_TIMING, {8'h00, 2'(c), 6'h01});
            @(posedge clk);
            #1 chk("jump width", {13'h0, rjw}, 16'(c + 1));
        end
        for (int p = 0; p < 64; p += 21) begin
            wr(OFF_TIMING, 16'(p));
            repeat (3) tk();
            chk("quantum", 16'(n), 16'(2 * p + 2));
        end
        for (int f = 1; f < 16; f++) begin
            wr(OFF_SID_BASE + 8'(f), 16'hFFE3);
            wr(OFF_EID_BASE + 8'(f), 16'hFFFF);
        end
        wr(OFF_SID_BASE, 16'hB462);
        wr(OFF_EID_BASE, 16'h1234);
        rx(0, 0, 11'h5A3, 18'h0, 1);
        rx(0, 0, 11'h5A2, 18'h0, 0);
        rx(1, 0, 11'h5A3, 18'h21234, 1);
        rx(1, 0, 11'h5A3, 18'h01234, 0);
        rx(1, 0, 11'h5A3, 18'h21235, 0);
        @(posedge clk) enf <= 16'h0001;
        rx(1, 0, 11'h5A3, 18'h21234, 0);
        wr(OFF_SID_BASE, 16'hB46A);
        rx(0, 0, 11'h5A3, 18'h0, 0);
        rx(1, 0, 11'h5A3, 18'h21234, 1);
        wr(OFF_SID_BASE, 16'hB462);
        @(posedge clk) enf <= 16'h0000;
        rc(OFF_INT_STATUS, 16'h0010, 16'h0010);
        wr(OFF_INT_STATUS, 16'h001F);
        wr(OFF_INT_MASK, 16'h000F);
        outcome <= 2'h1;
        wr(OFF_PAIR_BASE, 16'h888B);
        ws(3'h0);
        outcome <= 2'h0;
        ws(3'h0);
        ws(3'h1);
        wd();
        rc(OFF_PAIR_BASE, 16'h8888, 16'h8080);
        rc(OFF_INT_STATUS, 16'h000F, 16'h0005);
        outcome <= 2'h2;
        wr(OFF_PAIR_BASE + 8'h01, 16'h8B8B);
        ws(3'h3);
        outcome <= 2'h0;
        ws(3'h3);
        ws(3'h2);
        wd();
        rc(OFF_INT_STATUS, 16'h000F, 16'h000D);
        wr(OFF_INT_STATUS, 16'h001F);
        wr(OFF_INT_MASK, 16'h0000);
        slow <= 1'b1;
        wr(OFF_PAIR_BASE, 16'h8088);
        ws(3'h0);
        wr(OFF_PAIR_BASE, 16'h8080);
        wd();
        chk("irq", {15'h0, irq}, 16'h0000);
        rc(OFF_PAIR_BASE, 16'hFFFF, 16'h80C0);
        wr(OFF_INT_MASK, 16'h0002);
        @(posedge clk);
        #1 chk("irq", {15'h0, irq}, 16'h0001);
        wr(OFF_PAIR_BASE, 16'h8088);
        rc(OFF_PAIR_BASE, 16'h0070, 16'h0000);
        ws(3'h0);
        wd();
        rc(OFF_PAIR_BASE, 16'h00F8, 16'h0080);
        wr(OFF_INT_STATUS, 16'h001F);
        @(posedge clk);
        #1 chk("irq", {15'h0, irq}, 16'h0000);
        slow <= 1'b0;
        wr(OFF_PAIR_BASE + 8'h01, 16'h8084);
        rx(0, 1, 11'h5A3, 18'h0, 1);
        ws(3'h2);
        wd();
        chk("extra starts", 16'(started.size()), 16'h0000);
        complete_run();
    end
endmodule // can_buffer_ctrl_tb
